//--- src/iocg_pkg.sv
// constants and types for the io cell group gearbox and tri-state path
package iocg_pkg;
  // ==========================================================
  // gearbox modes
  typedef enum logic [2:0] {
    IOCG_MODE_VIDEO7 = 3'b001,
    IOCG_MODE_EIGHT = 3'b010,
    IOCG_MODE_FOUR = 3'b100
  } iocg_mode_t;

  // ==========================================================
  // widths and counts
  localparam int IOCG_WORD_W = 8;
  localparam int IOCG_LANE_W = 4;
  localparam int IOCG_FIFO_DEPTH = 4;
  localparam logic [2:0] IOCG_LAST_VIDEO7 = 3'h6;
  localparam logic [2:0] IOCG_LAST_EIGHT = 3'h7;
  localparam logic [2:0] IOCG_LAST_FOUR = 3'h3;
  localparam logic [2:0] IOCG_CNT_RESET = 3'h0;
  localparam logic [7:0] IOCG_WORD_RESET = 8'h00;
  localparam logic IOCG_OE_RESET = 1'b0;
  localparam logic IOCG_RIGHT_EDGE_DEFAULT = 1'b1;

  // last bit index of a word for a mode
  function automatic logic [2:0] iocg_last_bit(input iocg_mode_t mode);
    logic [2:0] last;
    last = IOCG_LAST_EIGHT;
    unique case (mode)
      IOCG_MODE_VIDEO7: last = IOCG_LAST_VIDEO7;
      IOCG_MODE_EIGHT: last = IOCG_LAST_EIGHT;
      IOCG_MODE_FOUR: last = IOCG_LAST_FOUR;
      default: last = IOCG_LAST_EIGHT;
    endcase
    return last;
  endfunction : iocg_last_bit
endpackage : iocg_pkg

//--- src/iocg_fifo_if.sv
// word stream between gearbox and its output fifo
`timescale 1ns/10ps
interface iocg_fifo_if #(parameter int WIDTH = 8);
  logic wrValid;
  logic wrReady;
  logic [WIDTH-1:0] wrData;
  logic rdValid;
  logic rdReady;
  logic [WIDTH-1:0] rdData;
  modport fifo (input wrValid, input wrData, output wrReady,
                output rdValid, output rdData, input rdReady);
  modport user (output wrValid, output wrData, input wrReady,
                input rdValid, input rdData, output rdReady);
endinterface : iocg_fifo_if

//--- src/iocg_fifo.sv
// small word fifo for the parallel gearbox output
`timescale 1ns/10ps
module iocg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic ref_clk,
  input wire logic nrst,
  iocg_fifo_if.fifo port
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] count;
  logic doWr;
  logic doRd;

  assign port.wrReady = (count != (AW+1)'(DEPTH));
  assign port.rdValid = (count != '0);
  assign port.rdData = mem[rdPtr];
  assign doWr = port.wrValid && port.wrReady;
  assign doRd = port.rdValid && port.rdReady;

  always_ff @(posedge ref_clk) begin
    if (doWr) begin
      mem[wrPtr] <= port.wrData;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (doWr) begin
        wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      end
      if (doRd) begin
        rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      end
      count <= count + (AW+1)'(doWr) - (AW+1)'(doRd);
    end
  end

  fifo_bounds_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    count <= (AW+1)'(DEPTH))
    else $error("fifo count beyond depth");
  fifo_full_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (!port.wrReady && !doRd) |=> !port.wrReady)
    else $error("full fifo lost a word");
endmodule : iocg_fifo

//--- src/iocg_top.sv
// input gearbox and tri-state register path of one io cell group
`timescale 1ns/10ps
module iocg_top #(
  parameter logic RIGHT_EDGE = iocg_pkg::IOCG_RIGHT_EDGE_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic fastEdgeEn,
  input wire logic [2:0] gearMode,
  input wire logic serialFirst,
  input wire logic serialThird,
  input wire logic word_align_request,
  input wire logic wordReady,
  output logic wordValid,
  output logic [7:0] wordData,
  output logic gearReady,
  output logic wordDropped,
  input wire logic core_tristate_ctrl_in,
  input wire logic ddr_tristate_ctrl_in,
  input wire logic ddrMemMode,
  input wire logic write_strobe_quarter_shift_clock,
  output logic tristateOe
);
  // ==========================================================
  // gearbox
  iocg_pkg::iocg_mode_t mode;
  iocg_pkg::iocg_mode_t modeQ;
  logic [2:0] bitCnt;
  logic [2:0] lastBit;
  logic [7:0] shiftFirst;
  logic [3:0] shiftThird;
  logic [7:0] next_word;
  logic alignQ;
  logic slipPending;
  logic slipNow;
  logic wordDone;
  logic pushValid;
  logic [7:0] pushWord;
  iocg_fifo_if #(.WIDTH(iocg_pkg::IOCG_WORD_W)) fifoBus ();

  // illegal mode codes fall back to eight-bit
  always_comb begin
    unique case (gearMode)
      iocg_pkg::IOCG_MODE_VIDEO7: mode = iocg_pkg::IOCG_MODE_VIDEO7;
      iocg_pkg::IOCG_MODE_FOUR: mode = iocg_pkg::IOCG_MODE_FOUR;
      default: mode = iocg_pkg::IOCG_MODE_EIGHT;
    endcase
  end

  assign lastBit = iocg_pkg::iocg_last_bit(mode);
  assign slipNow = slipPending && fastEdgeEn;
  assign wordDone = fastEdgeEn && !slipPending && (bitCnt == lastBit);

  // serial bits enter on fast edge enable, newest in bit 0
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      shiftFirst <= iocg_pkg::IOCG_WORD_RESET;
      shiftThird <= iocg_pkg::IOCG_WORD_RESET[3:0];
    end else if (fastEdgeEn) begin
      shiftFirst <= {shiftFirst[6:0], serialFirst};
      shiftThird <= {shiftThird[2:0], serialThird};
    end
  end

  // request edge arms a one-bit slip; a new edge wins over consumption
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      alignQ <= 1'b0;
      slipPending <= 1'b0;
    end else begin
      alignQ <= word_align_request;
      if (word_align_request && !alignQ) begin
        slipPending <= 1'b1;
      end else if (slipNow) begin
        slipPending <= 1'b0;
      end
    end
  end

  // holding the count for one bit moves the boundary by one bit
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      bitCnt <= iocg_pkg::IOCG_CNT_RESET;
      modeQ <= iocg_pkg::IOCG_MODE_EIGHT;
    end else begin
      modeQ <= mode;
      if (mode != modeQ) begin
        bitCnt <= iocg_pkg::IOCG_CNT_RESET;
      end else if (fastEdgeEn && !slipPending) begin
        bitCnt <= (bitCnt == lastBit) ? iocg_pkg::IOCG_CNT_RESET : bitCnt + 3'h1;
      end
    end
  end

  always_comb begin
    next_word = iocg_pkg::IOCG_WORD_RESET;
    unique case (mode)
      iocg_pkg::IOCG_MODE_VIDEO7: next_word = {1'b0, shiftFirst[5:0], serialFirst};
      iocg_pkg::IOCG_MODE_EIGHT: next_word = {shiftFirst[6:0], serialFirst};
      iocg_pkg::IOCG_MODE_FOUR: next_word = {shiftFirst[2:0], serialFirst,
                                            shiftThird[2:0], serialThird};
      default: next_word = {shiftFirst[6:0], serialFirst};
    endcase
  end

  // a word pushed while the fifo is full is lost and flagged the next cycle
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pushValid <= 1'b0;
      pushWord <= iocg_pkg::IOCG_WORD_RESET;
      wordDropped <= 1'b0;
    end else begin
      pushValid <= wordDone && (mode == modeQ);
      wordDropped <= pushValid && !fifoBus.wrReady;
      if (wordDone) begin
        pushWord <= next_word;
      end
    end
  end

  assign fifoBus.wrValid = pushValid;
  assign fifoBus.wrData = pushWord;
  assign fifoBus.rdReady = wordReady;
  assign wordValid = fifoBus.rdValid;
  assign wordData = fifoBus.rdData;
  assign gearReady = fifoBus.wrReady;

  iocg_fifo #(
    .WIDTH(iocg_pkg::IOCG_WORD_W),
    .DEPTH(iocg_pkg::IOCG_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .port(fifoBus.fifo)
  );

  // ==========================================================
  // tri-state register path
  logic sdrReg;
  logic ddrFirst;
  logic strobeReg;
  logic ddrActive;

  // ddr stage exists only on the right edge; elsewhere mode pin is ignored
  assign ddrActive = RIGHT_EDGE && ddrMemMode;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sdrReg <= iocg_pkg::IOCG_OE_RESET;
      ddrFirst <= iocg_pkg::IOCG_OE_RESET;
    end else begin
      sdrReg <= core_tristate_ctrl_in;
      ddrFirst <= ddr_tristate_ctrl_in;
    end
  end

  // strobe arrives as an enable pulse in this single-clock build
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      strobeReg <= iocg_pkg::IOCG_OE_RESET;
    end else if (write_strobe_quarter_shift_clock) begin
      strobeReg <= ddrFirst;
    end
  end

  assign tristateOe = ddrActive ? strobeReg : sdrReg;

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sdr_oe_follow_a: assert property (
    (!ddrActive && $past(!ddrActive) && $past(nrst)) |-> tristateOe == $past(core_tristate_ctrl_in))
    else $error("sdr enable not one flop behind core");
  // a reset in the previous cycle clears the stage, so those cycles are skipped
  ddr_oe_load_a: assert property (
    (ddrActive && $past(ddrActive) && $past(nrst) && $past(write_strobe_quarter_shift_clock))
      |-> tristateOe == $past(ddrFirst))
    else $error("ddr enable did not load on strobe");
  ddr_oe_hold_a: assert property (
    (ddrActive && $past(ddrActive) && $past(nrst) && !$past(write_strobe_quarter_shift_clock))
      |-> $stable(tristateOe))
    else $error("ddr enable moved without strobe");
  ddr_edge_only_a: assert property (
    (!RIGHT_EDGE && $past(nrst)) |-> tristateOe == $past(core_tristate_ctrl_in))
    else $error("left edge enable not plain sdr");
  video_msb_zero_a: assert property (
    (pushValid && modeQ == iocg_pkg::IOCG_MODE_VIDEO7 && $past(mode == modeQ))
      |-> !pushWord[7])
    else $error("video word uses bit 7");
  four_lane_map_a: assert property (
    (wordDone && mode == iocg_pkg::IOCG_MODE_FOUR)
      |=> pushWord[4] == $past(serialFirst) && pushWord[0] == $past(serialThird))
    else $error("four-bit lanes misplaced");
  slip_hold_a: assert property (
    (slipNow && mode == modeQ) |=> $stable(bitCnt))
    else $error("slip did not hold the bit count");
  word_done_push_a: assert property (
    (wordDone && mode == modeQ) |=> pushValid ##1 (wordDropped == !$past(gearReady)))
    else $error("finished word not pushed");
  count_range_a: assert property (
    (mode == modeQ) |-> bitCnt <= lastBit)
    else $error("bit count beyond word length");
  mode_restart_a: assert property (
    (mode != modeQ) |=> (bitCnt == iocg_pkg::IOCG_CNT_RESET) && !pushValid)
    else $error("mode change did not restart the word");
  serial_shift_a: assert property (
    fastEdgeEn |=> shiftFirst[0] == $past(serialFirst))
    else $error("serial bit not taken on edge enable");
  serial_idle_a: assert property (
    !fastEdgeEn |=> $stable(shiftFirst))
    else $error("shift register moved without edge enable");
  align_arm_a: assert property (
    (word_align_request && !alignQ) |=> slipPending)
    else $error("request edge did not arm a slip");
  slip_consume_a: assert property (
    (slipNow && !(word_align_request && !alignQ)) |=> !slipPending)
    else $error("slip stayed pending after use");
  push_source_a: assert property (
    pushValid |-> $past(wordDone))
    else $error("push without a finished word");
  drop_source_a: assert property (
    wordDropped |-> $past(pushValid))
    else $error("drop flagged without a push");

  cov_slip_c: cover property (slipNow ##[1:16] pushValid);
  cov_four_c: cover property (pushValid && modeQ == iocg_pkg::IOCG_MODE_FOUR);
  cov_drop_c: cover property (wordDropped);
  cov_ddr_c: cover property (ddrActive && write_strobe_quarter_shift_clock ##1 $changed(tristateOe));
endmodule : iocg_top

//--- tb/iocg_serial_tx.sv
// serial transmitter model driving both gearbox lanes
`timescale 1ns/10ps
module iocg_serial_tx (
  input wire logic ref_clk,
  output logic fastEdgeEn,
  output logic serialFirst,
  output logic serialThird
);
  initial begin
    fastEdgeEn = 1'b0;
    serialFirst = 1'b0;
    serialThird = 1'b0;
  end

  // ==========================================================
  // frame sender
  // first bit sent is the word msb, one bit per enabled cycle
  task automatic send(input logic [8:0] first, input logic [8:0] third, input int nBits);
    for (int i = nBits - 1; i >= 0; i--) begin
      @(negedge ref_clk);
      fastEdgeEn <= 1'b1;
      serialFirst <= first[i];
      serialThird <= third[i];
    end
    @(negedge ref_clk);
    fastEdgeEn <= 1'b0;
    // idle lines flip so a stale bit never passes for data
    serialFirst <= ~serialFirst;
    serialThird <= ~serialThird;
  endtask : send
endmodule : iocg_serial_tx

//--- tb/tb_io_cell_input_deser_tristate.sv
// self-checking bench for the gearbox and tri-state path
`timescale 1ns/10ps
module tb_io_cell_input_deser_tristate;
  logic ref_clk, nrst, fastEdgeEn, serialFirst, serialThird, alignReq, wordReady;
  logic wordValid, gearReady, wordDropped, coreOe, ddrOe, ddrMemMode, strobe, tristateOe;
  logic [2:0] gearMode;
  logic [7:0] wordData;
  logic tristateOeLeft;
  int failCount, nChecks;

  iocg_serial_tx tx (.ref_clk(ref_clk), .fastEdgeEn(fastEdgeEn), .serialFirst(serialFirst),
    .serialThird(serialThird));
  iocg_top uut (.ref_clk(ref_clk), .nrst(nrst), .fastEdgeEn(fastEdgeEn), .gearMode(gearMode),
    .serialFirst(serialFirst), .serialThird(serialThird), .word_align_request(alignReq),
    .wordReady(wordReady), .wordValid(wordValid), .wordData(wordData), .gearReady(gearReady),
    .wordDropped(wordDropped), .core_tristate_ctrl_in(coreOe), .ddr_tristate_ctrl_in(ddrOe),
    .ddrMemMode(ddrMemMode), .write_strobe_quarter_shift_clock(strobe),
    .tristateOe(tristateOe));
  // left-edge copy: no ddr stage, so its enable must stay on the sdr flop
  iocg_top #(.RIGHT_EDGE(1'b0)) uutLeft (.ref_clk(ref_clk), .nrst(nrst),
    .fastEdgeEn(fastEdgeEn), .gearMode(gearMode), .serialFirst(serialFirst),
    .serialThird(serialThird), .word_align_request(alignReq), .wordReady(wordReady),
    .wordValid(), .wordData(), .gearReady(), .wordDropped(),
    .core_tristate_ctrl_in(coreOe), .ddr_tristate_ctrl_in(ddrOe),
    .ddrMemMode(ddrMemMode), .write_strobe_quarter_shift_clock(strobe),
    .tristateOe(tristateOeLeft));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ==========================================================
  // helpers
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    nChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic finishTest;
    $display("checks %0d, mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finishTest

  task automatic tick;
    @(negedge ref_clk);
  endtask : tick

  // bounded wait so a lost word ends the run instead of hanging it
  task automatic popWord(input logic [7:0] exp);
    for (int i = 0; i < 12 && wordValid !== 1'b1; i++) tick();
    if (wordValid !== 1'b1) begin
      failCount++;
      finishTest();
    end
    check("wordData", wordData, exp);
    wordReady <= 1'b1;
    tick();
    wordReady <= 1'b0;
    tick();
  endtask : popWord

  // ==========================================================
  // scenarios
  task automatic testModes;
    gearMode <= iocg_pkg::IOCG_MODE_EIGHT;
    tick();
    tx.send({1'b0, 8'hA5}, 9'h000, 8);
    popWord(8'hA5);
    gearMode <= iocg_pkg::IOCG_MODE_VIDEO7;
    tick();
    tx.send(9'h055, 9'h000, 7);
    popWord(8'h55);
    gearMode <= iocg_pkg::IOCG_MODE_FOUR;
    tick();
    tx.send(9'h00C, 9'h003, 4);
    popWord(8'hC3);
    // an unused mode code must behave as eight-bit
    gearMode <= 3'h0;
    tick();
    tx.send({1'b0, 8'h96}, 9'h000, 8);
    popWord(8'h96);
  endtask : testModes

  // request held high across the frame: only one bit of slip allowed
  task automatic testAlign;
    gearMode <= iocg_pkg::IOCG_MODE_EIGHT;
    tick();
    alignReq <= 1'b1;
    tx.send({1'b1, 8'h3C}, 9'h000, 9);
    popWord(8'h3C);
    alignReq <= 1'b0;
  endtask : testAlign

  task automatic testFifo;
    for (int k = 1; k <= 5; k++) tx.send({1'b0, 8'(k * 17)}, 9'h000, 8);
    for (int i = 0; i < 6 && wordDropped !== 1'b1; i++) tick();
    check("wordDropped", {7'h00, wordDropped}, 8'h01);
    check("gearReady", {7'h00, gearReady}, 8'h00);
    for (int k = 1; k <= 4; k++) popWord(8'(k * 17));
    check("wordValid", {7'h00, wordValid}, 8'h00);
    check("gearReady", {7'h00, gearReady}, 8'h01);
  endtask : testFifo

  task automatic testTristate;
    coreOe <= 1'b1;
    tick();
    check("sdr oe", {7'h00, tristateOe}, 8'h01);
    coreOe <= 1'b0;
    tick();
    check("sdr oe", {7'h00, tristateOe}, 8'h00);
    ddrMemMode <= 1'b1;
    coreOe <= 1'b1;
    ddrOe <= 1'b1;
    tick();
    check("ddr oe", {7'h00, tristateOe}, 8'h00);
    check("left oe", {7'h00, tristateOeLeft}, 8'h01);
    strobe <= 1'b1;
    tick();
    check("ddr oe", {7'h00, tristateOe}, 8'h01);
    strobe <= 1'b0;
    ddrOe <= 1'b0;
    coreOe <= 1'b0;
    tick();
    tick();
    check("ddr oe", {7'h00, tristateOe}, 8'h01);
    check("left oe", {7'h00, tristateOeLeft}, 8'h00);
  endtask : testTristate

  // ==========================================================
  // main sequence
  initial begin
    failCount = 0;
    nChecks = 0;
    nrst = 1'b0;
    gearMode = iocg_pkg::IOCG_MODE_EIGHT;
    alignReq = 1'b0;
    wordReady = 1'b0;
    coreOe = 1'b0;
    ddrOe = 1'b0;
    ddrMemMode = 1'b0;
    strobe = 1'b0;
    repeat (5) tick();
    nrst <= 1'b1;
    tick();
    check("wordValid", {7'h00, wordValid}, 8'h00);
    check("gearReady", {7'h00, gearReady}, 8'h01);
    check("reset oe", {7'h00, tristateOe}, 8'h00);
    testModes();
    testAlign();
    testFifo();
    testTristate();
    finishTest();
  end
endmodule : tb_io_cell_input_deser_tristate
